// ### verilog/clk_ctrl_pkg.sv
// constants for the clock source and power mode controller
package clk_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_0 = 8'h00;
  localparam logic [7:0] OFS_CTRL_1 = 8'h04;
  localparam logic [7:0] OFS_CTRL_2 = 8'h08;
  localparam logic [7:0] OFS_DIVIDER = 8'h0C;
  localparam logic [7:0] OFS_PROC_MODE = 8'h10;
  localparam logic [7:0] OFS_PLL_CTRL = 8'h14;
  localparam logic [7:0] OFS_PROTECT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_WAIT_CMD = 8'h20;
  // field positions, clock_ctrl_0
  localparam int B_PSTOP_WAIT = 2;
  localparam int B_SUB_DRIVE = 3;
  localparam int B_SUB_EN = 4;
  localparam int B_MAIN_STOP = 5;
  localparam int B_SUB_SEL = 7;
  // clock_ctrl_1
  localparam int B_ALL_STOP = 0;
  localparam int B_PLL_SEL = 7;
  // clock_ctrl_2
  localparam int B_OCO_SEL = 1;
  // processor_mode_1
  localparam int B_WAIT_INS = 2;
  // pll_control
  localparam int B_PLL_ON = 7;
  // protect register
  localparam int B_UNLOCK2 = 2;
  // reset values
  localparam logic [7:0] RST_CTRL_0 = 8'h08;
  localparam logic [7:0] RST_CTRL_1 = 8'h00;
  localparam logic [7:0] RST_CTRL_2 = 8'h00;
  localparam logic [4:0] RST_DIVIDER = 5'h08;
  localparam logic [7:0] RST_PROC_MODE = 8'h00;
  localparam logic [7:0] RST_PLL_CTRL = 8'h00;
  // glitch-free mux settle cycles per half of the switch
  localparam int SWITCH_SYNC_CYCLES = 3;
  // cpu clock source selection
  typedef enum logic [1:0] {SRC_MAIN, SRC_OCO, SRC_PLL, SRC_SUB} clk_src_t;
  // power modes
  typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} power_mode_t;
endpackage

// ### verilog/clk_switch_gate.sv
// glitch-free handover between two clock enables
`timescale 1ns/1ns
`default_nettype none
module clk_switch_gate
  import clk_ctrl_pkg::*;
#(
  parameter int SETTLE = SWITCH_SYNC_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request
  input wire clk_src_t src_req_i,
  input wire logic [3:0] src_stable_i,
  // result
  output clk_src_t src_act_o,
  output logic gate_on_o,
  output logic busy_o
);
  typedef enum {SW_RUN, SW_OFF, SW_ON} sw_state_t;
  sw_state_t state_reg;
  logic [3:0] cnt_reg;
  clk_src_t act_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SW_RUN;
      cnt_reg <= 4'h0;
      act_reg <= SRC_MAIN;
    end else begin
      unique case (state_reg)
        // only switch once the new source is stable
        SW_RUN: begin
          if (src_req_i != act_reg && src_stable_i[src_req_i]) begin
            state_reg <= SW_OFF;
            cnt_reg <= 4'(SETTLE);
          end
        end
        SW_OFF: begin
          if (cnt_reg == 4'h0) begin
            act_reg <= src_req_i;
            state_reg <= SW_ON;
            cnt_reg <= 4'(SETTLE);
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        SW_ON: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= SW_RUN;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // output gated during both settle halves, no truncated pulse
  assign gate_on_o = (state_reg == SW_RUN);
  assign busy_o = (state_reg != SW_RUN);
  assign src_act_o = act_reg;

  AST_NO_GATE_WHILE_SWITCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(act_reg) |-> !gate_on_o) else $error("source changed with gate open");
endmodule // clk_switch_gate
`default_nettype wire

// ### verilog/clock_source_power_mode_ctrl.sv
// clock source selection, power modes and write protect, AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
module clock_source_power_mode_ctrl
  import clk_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins and wake events
  input wire logic nmi_n_i,
  input wire logic wake_irq_i,
  input wire logic [3:0] src_stable_i,
  // cpu side
  input wire logic cpu_any_write_i,
  output logic prefetch_first_o,
  // clock outputs
  output clk_src_t cpu_src_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic sub_periph_clk_en_o,
  output logic [4:0] main_divider_field_o,
  output logic subosc_enable_o,
  output logic subosc_drive_high_o,
  output logic main_clock_stop_o,
  output logic pll_on_o,
  output logic wait_state_insert_o,
  output power_mode_t power_mode_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] clock_ctrl_0_reg, clock_ctrl_1_reg, clock_ctrl_2_reg;
  logic [7:0] processor_mode_1_reg, pll_control_reg;
  logic [4:0] main_divider_reg;
  logic protect_unlock_2_reg;
  power_mode_t mode_reg;
  logic [2:0] nmi_sync_reg;
  logic nmi_level_reg;
  logic wr_pend_reg, rd_pend_reg;
  logic [7:0] addr_reg;
  logic prefetch_reg;
  logic stop_req, wait_req, wake, sw_busy, gate_on;
  clk_src_t src_req;

  // nmi pin synchroniser, change counts once stages 2 and 3 agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nmi_sync_reg <= 3'b111;
      nmi_level_reg <= 1'b1;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_n_i};
      if (nmi_sync_reg[2] == nmi_sync_reg[1]) begin
        nmi_level_reg <= nmi_sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase capture, zero wait states
  wire bus_take = hsel && hready && htrans[1];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_take && hwrite;
      rd_pend_reg <= bus_take && !hwrite;
      if (bus_take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wr_ctrl0 = wr_pend_reg && addr_reg == OFS_CTRL_0;
  wire wr_ctrl1 = wr_pend_reg && addr_reg == OFS_CTRL_1;
  wire wr_ctrl2 = wr_pend_reg && addr_reg == OFS_CTRL_2;
  wire wr_prot = wr_pend_reg && addr_reg == OFS_PROTECT;
  wire wr_waitc = wr_pend_reg && addr_reg == OFS_WAIT_CMD && hwdata[0];
  // unlocked clock registers accept writes only with the second unlock set
  wire unlocked = protect_unlock_2_reg;

  assign stop_req = wr_ctrl1 && unlocked && hwdata[B_ALL_STOP] && mode_reg == PM_RUN;
  assign wait_req = wr_waitc && mode_reg == PM_RUN;
  assign wake = wake_irq_i || !nmi_level_reg;

  ////////////////////////////////////////////////////////////////////////////
  // clock control 0, drive bit forced high on stop entry
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_ctrl_0_reg <= RST_CTRL_0;
    end else begin
      if (wr_ctrl0 && unlocked) begin
        clock_ctrl_0_reg <= hwdata[7:0];
      end
      if (stop_req && nmi_level_reg) begin
        clock_ctrl_0_reg[B_SUB_DRIVE] <= 1'b1;
      end
    end
  end

  // clock control 1, 2, divider, mode and pll registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_ctrl_1_reg <= RST_CTRL_1;
      clock_ctrl_2_reg <= RST_CTRL_2;
      main_divider_reg <= RST_DIVIDER;
      processor_mode_1_reg <= RST_PROC_MODE;
      pll_control_reg <= RST_PLL_CTRL;
    end else begin
      if (wr_ctrl1 && unlocked) begin
        clock_ctrl_1_reg <= hwdata[7:0] & ~(8'h01 << B_ALL_STOP);
      end
      if (wr_ctrl2 && unlocked) begin
        clock_ctrl_2_reg <= hwdata[7:0];
      end
      if (wr_pend_reg && addr_reg == OFS_DIVIDER && unlocked) begin
        main_divider_reg <= hwdata[4:0];
      end
      if (wr_pend_reg && addr_reg == OFS_PROC_MODE && unlocked) begin
        processor_mode_1_reg <= hwdata[7:0];
      end
      if (wr_pend_reg && addr_reg == OFS_PLL_CTRL && unlocked) begin
        pll_control_reg <= hwdata[7:0];
      end
    end
  end

  // second unlock: any later write other than to the protect register closes it again
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      protect_unlock_2_reg <= 1'b0;
    end else if (wr_prot) begin
      protect_unlock_2_reg <= hwdata[B_UNLOCK2];
    end else if (wr_pend_reg || cpu_any_write_i) begin
      protect_unlock_2_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode sequencing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= PM_RUN;
      prefetch_reg <= 1'b0;
    end else begin
      prefetch_reg <= 1'b0;
      unique case (mode_reg)
        PM_RUN: begin
          if (stop_req && nmi_level_reg) begin
            mode_reg <= PM_STOP;
          end else if (wait_req) begin
            mode_reg <= PM_WAIT;
          end
        end
        PM_WAIT, PM_STOP: begin
          if (wake) begin
            mode_reg <= PM_RUN;
            prefetch_reg <= 1'b1;
          end
        end
        default: mode_reg <= PM_RUN;
      endcase
    end
  end

  // requested cpu source
  always_comb begin
    if (clock_ctrl_0_reg[B_SUB_SEL]) begin
      src_req = SRC_SUB;
    end else if (clock_ctrl_2_reg[B_OCO_SEL]) begin
      src_req = SRC_OCO;
    end else if (clock_ctrl_1_reg[B_PLL_SEL]) begin
      src_req = SRC_PLL;
    end else begin
      src_req = SRC_MAIN;
    end
  end

  clk_switch_gate #(
    .SETTLE(SWITCH_SYNC_CYCLES)
  ) u_switch (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .src_req_i(src_req),
    .src_stable_i(src_stable_i),
    .src_act_o(cpu_src_o),
    .gate_on_o(gate_on),
    .busy_o(sw_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock enables per mode
  wire pstop = clock_ctrl_0_reg[B_PSTOP_WAIT];
  assign cpu_clk_en_o = gate_on && mode_reg == PM_RUN;
  assign periph_clk_en_o = mode_reg == PM_RUN || (mode_reg == PM_WAIT && !pstop);
  // sub peripheral clock keeps running through wait
  assign sub_periph_clk_en_o = mode_reg != PM_STOP && clock_ctrl_0_reg[B_SUB_EN];
  assign main_divider_field_o = main_divider_reg;
  assign subosc_enable_o = clock_ctrl_0_reg[B_SUB_EN];
  assign subosc_drive_high_o = clock_ctrl_0_reg[B_SUB_DRIVE];
  assign main_clock_stop_o = clock_ctrl_0_reg[B_MAIN_STOP] || mode_reg == PM_STOP;
  assign pll_on_o = pll_control_reg[B_PLL_ON] && mode_reg != PM_STOP;
  assign wait_state_insert_o = processor_mode_1_reg[B_WAIT_INS];
  assign power_mode_o = mode_reg;
  assign prefetch_first_o = prefetch_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL_0: hrdata <= {24'h00_0000, clock_ctrl_0_reg};
        OFS_CTRL_1: hrdata <= {24'h00_0000, clock_ctrl_1_reg};
        OFS_CTRL_2: hrdata <= {24'h00_0000, clock_ctrl_2_reg};
        OFS_DIVIDER: hrdata <= {27'h000_0000, main_divider_reg};
        OFS_PROC_MODE: hrdata <= {24'h00_0000, processor_mode_1_reg};
        OFS_PLL_CTRL: hrdata <= {24'h00_0000, pll_control_reg};
        OFS_PROTECT: hrdata <= {29'h0000_0000, protect_unlock_2_reg, 2'b00};
        OFS_STATUS: hrdata <= {27'h000_0000, sw_busy, cpu_src_o, mode_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_STOP_FORCES_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode_reg == PM_RUN ##1 mode_reg == PM_STOP) |-> subosc_drive_high_o)
    else $error("stop entered without high drive");
  AST_UNLOCK_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (protect_unlock_2_reg && wr_pend_reg && !wr_prot) |=> !protect_unlock_2_reg)
    else $error("unlock survived a write");
  AST_NO_STOP_NMI_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode_reg == PM_RUN && !nmi_level_reg) |=> mode_reg != PM_STOP)
    else $error("stop entered with nmi low");
  AST_WAKE_PREFETCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode_reg == PM_STOP && wake) |=> (prefetch_first_o && mode_reg == PM_RUN))
    else $error("wake without queued instruction slot");
  AST_SUB_PERIPH_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode_reg == PM_WAIT && subosc_enable_o) |-> sub_periph_clk_en_o)
    else $error("sub peripheral clock gated in wait");
  AST_STOP_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (stop_req && nmi_level_reg) |=> (mode_reg == PM_STOP && !cpu_clk_en_o))
    else $error("all stop write did not stop");
  AST_GATE_STABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(cpu_src_o) |-> !cpu_clk_en_o ##1 !cpu_clk_en_o[*3])
    else $error("cpu clock open across switch");
  AST_STOP_HALTS_PLL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_reg == PM_STOP |-> (!pll_on_o && main_clock_stop_o && !periph_clk_en_o))
    else $error("clock running in stop");
  COV_STOP_WAKE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_reg == PM_STOP ##[1:50] mode_reg == PM_RUN);
  COV_WAIT: cover property (@(posedge clk_i) disable iff (!rst_n_i) mode_reg == PM_WAIT);
  COV_SWITCH: cover property (@(posedge clk_i) disable iff (!rst_n_i) $changed(cpu_src_o));
endmodule // clock_source_power_mode_ctrl
`default_nettype wire

// ### test/clock_source_power_mode_ctrl_tb_top.sv
// self-checking bench for the clock source and power mode controller
`timescale 1ns/1ns
`default_nettype none
module clock_source_power_mode_ctrl_tb_top;
  import clk_ctrl_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic nmi_n_i = 1'b1;
  logic wake_irq_i = 1'b0;
  logic [3:0] src_stable_i = 4'b0001;
  logic cpu_any_write_i = 1'b0;
  logic prefetch_first_o, cpu_clk_en_o, periph_clk_en_o, sub_periph_clk_en_o;
  logic subosc_enable_o, subosc_drive_high_o, main_clock_stop_o, pll_on_o;
  logic wait_state_insert_o;
  logic [4:0] main_divider_field_o;
  clk_src_t cpu_src_o;
  power_mode_t power_mode_o;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [31:0] q;
  logic seen;
  assign hready = hreadyout;
  always #5 clk_i = ~clk_i;
  clock_source_power_mode_ctrl DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nmi_n_i(nmi_n_i), .wake_irq_i(wake_irq_i),
    .src_stable_i(src_stable_i), .cpu_any_write_i(cpu_any_write_i),
    .prefetch_first_o(prefetch_first_o), .cpu_src_o(cpu_src_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .sub_periph_clk_en_o(sub_periph_clk_en_o),
    .main_divider_field_o(main_divider_field_o), .subosc_enable_o(subosc_enable_o),
    .subosc_drive_high_o(subosc_drive_high_o), .main_clock_stop_o(main_clock_stop_o),
    .pll_on_o(pll_on_o), .wait_state_insert_o(wait_state_insert_o),
    .power_mode_o(power_mode_o)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask
  // unlock immediately followed by the protected write, nothing in between
  task automatic pwr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, OFS_PROTECT, 32'h0000_0004);
    bus(1'b1, a, d);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // raise a wake request and look for the one-cycle queued-instruction pulse
  task automatic wake();
    seen = 1'b0;
    @(posedge clk_i);
    wake_irq_i <= 1'b1;
    for (n = 0; n < 20 && !seen; n++) begin
      @(posedge clk_i);
      #1;
      if (prefetch_first_o === 1'b1) begin
        seen = 1'b1;
        chk("power_mode_o at pulse", 32'(PM_RUN), 32'(power_mode_o));
      end
    end
    @(posedge clk_i);
    wake_irq_i <= 1'b0;
    chk("prefetch_first_o", 32'h0000_0001, 32'(seen));
    settle();
  endtask
  // follow a source switch: gate closed as the source changes, open once settled
  task automatic wait_src(input clk_src_t s);
    for (n = 0; n < 40 && cpu_src_o !== s; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("cpu_clk_en_o in switch", 32'h0000_0000, 32'(cpu_clk_en_o));
    repeat (SWITCH_SYNC_CYCLES + 2) @(posedge clk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_CTRL_0, 32'h0000_0008, "ctrl0 reset");
    rd(OFS_DIVIDER, 32'h0000_0008, "divider reset");
    rd(8'h40, 32'h0000_0000, "unmapped read");
    bus(1'b1, OFS_CTRL_0, 32'h0000_0000);
    rd(OFS_CTRL_0, 32'h0000_0008, "ctrl0 locked");
    // sub oscillator start: sub not selected, drive high and enable in one write, then drive low
    pwr(OFS_CTRL_0, 32'h0000_0018);
    pwr(OFS_CTRL_0, 32'h0000_0010);
    bus(1'b1, OFS_CTRL_0, 32'h0000_0000);
    rd(OFS_CTRL_0, 32'h0000_0010, "ctrl0 relocked");
    bus(1'b1, OFS_PROTECT, 32'h0000_0004);
    rd(OFS_PROTECT, 32'h0000_0004, "unlock set");
    @(posedge clk_i);
    cpu_any_write_i <= 1'b1;
    @(posedge clk_i);
    cpu_any_write_i <= 1'b0;
    rd(OFS_PROTECT, 32'h0000_0000, "unlock after cpu write");
    bus(1'b1, OFS_CTRL_0, 32'h0000_0000);
    rd(OFS_CTRL_0, 32'h0000_0010, "ctrl0 after cpu write");
    // wait mode with peripheral stop, divider left at a slow setting
    pwr(OFS_CTRL_0, 32'h0000_0014);
    bus(1'b1, OFS_WAIT_CMD, 32'h0000_0001);
    settle();
    chk("power_mode_o wait", 32'(PM_WAIT), 32'(power_mode_o));
    chk("periph_clk_en_o wait", 32'h0000_0000, 32'(periph_clk_en_o));
    chk("sub_periph_clk_en_o wait", 32'h0000_0001, 32'(sub_periph_clk_en_o));
    wake();
    // pll switch only completes once the pll reports stable
    pwr(OFS_PLL_CTRL, 32'h0000_0080);
    settle();
    chk("pll_on_o", 32'h0000_0001, 32'(pll_on_o));
    pwr(OFS_CTRL_1, 32'h0000_0080);
    repeat (12) @(posedge clk_i);
    #1;
    chk("cpu_src_o unstable pll", 32'(SRC_MAIN), 32'(cpu_src_o));
    @(posedge clk_i);
    src_stable_i <= 4'b0101;
    wait_src(SRC_PLL);
    chk("cpu_src_o pll", 32'(SRC_PLL), 32'(cpu_src_o));
    chk("cpu_clk_en_o after switch", 32'h0000_0001, 32'(cpu_clk_en_o));
    pwr(OFS_CTRL_1, 32'h0000_0000);
    wait_src(SRC_MAIN);
    chk("cpu_src_o main", 32'(SRC_MAIN), 32'(cpu_src_o));
    pwr(OFS_PLL_CTRL, 32'h0000_0000);
    // stop refused while nmi held low
    nmi_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    pwr(OFS_CTRL_1, 32'h0000_0001);
    settle();
    chk("power_mode_o nmi low", 32'(PM_RUN), 32'(power_mode_o));
    @(posedge clk_i);
    nmi_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    // stop entry from main clock with drive low
    pwr(OFS_CTRL_1, 32'h0000_0001);
    settle();
    chk("power_mode_o stop", 32'(PM_STOP), 32'(power_mode_o));
    chk("cpu_clk_en_o stop", 32'h0000_0000, 32'(cpu_clk_en_o));
    chk("sub_periph_clk_en_o stop", 32'h0000_0000, 32'(sub_periph_clk_en_o));
    chk("subosc_drive_high_o stop", 32'h0000_0001, 32'(subosc_drive_high_o));
    wake();
    rd(OFS_CTRL_0, 32'h0000_001C, "ctrl0 after stop");
    // switch to sub clock once stable, drive low
    src_stable_i <= 4'b1001;
    pwr(OFS_CTRL_0, 32'h0000_0090);
    wait_src(SRC_SUB);
    chk("cpu_src_o sub", 32'(SRC_SUB), 32'(cpu_src_o));
    chk("subosc_drive_high_o sub", 32'h0000_0000, 32'(subosc_drive_high_o));
    rd(OFS_STATUS, 32'h0000_000C, "status sub run");
    // main clock may stop while sub drives the cpu
    pwr(OFS_CTRL_0, 32'h0000_00B0);
    settle();
    chk("main_clock_stop_o", 32'h0000_0001, 32'(main_clock_stop_o));
    pwr(OFS_DIVIDER, 32'h0000_0003);
    settle();
    chk("main_divider_field_o", 32'h0000_0003, 32'(main_divider_field_o));
    pwr(OFS_PROC_MODE, 32'h0000_0004);
    settle();
    chk("wait_state_insert_o", 32'h0000_0001, 32'(wait_state_insert_o));
    chk("subosc_enable_o", 32'h0000_0001, 32'(subosc_enable_o));
    chk("hresp", 32'h0000_0000, 32'(hresp));
    chk("hreadyout", 32'h0000_0001, 32'(hreadyout));
    close_out();
  end
endmodule // clock_source_power_mode_ctrl_tb_top
`default_nettype wire
